// ---- hdl/gsc_cmd.v ----
// i2c command handler for compensation, measurement and recalibration
`timescale 1ns/10ps
`include "gsc_regs.vh"
module gsc_cmd
(
   // clock and reset
   input wire sys_clk,
   input wire rst_b,
   // i2c pins, open drain
   input wire scl_in,
   input wire sda_in,
   output reg sda_out,
   output reg sda_oe,
   // configuration
   input wire [6:0] dev_addr,
   input wire restore_defaults,
   input wire gas_selected,
   // measurement core
   output reg meas_start,
   output reg meas_recal,
   output reg [15:0] recal_ref,
   input wire meas_done,
   input wire [15:0] meas_conc,
   input wire [15:0] internal_temp,
   input wire [15:0] meas_reserved,
   // compensation values in effect, checksum setting and status
   output reg [15:0] comp_rh,
   output reg [15:0] comp_temp,
   output reg [15:0] comp_press,
   output reg crc_enabled,
   output reg meas_busy,
   output reg data_ready
);
   localparam ST_IDLE = 3'd0;
   localparam ST_ADDR = 3'd1;
   localparam ST_WR = 3'd2;
   localparam ST_ACK = 3'd3;
   localparam ST_RD = 3'd4;
   localparam ST_RACK = 3'd5;

   // checksum over one 16-bit word
   function [7:0] crc8;
      input [15:0] word;
      integer i;
      reg [7:0] c;
      begin
         c = `GSC_CRC_INIT;
         for (i = 15; i >= 0; i = i - 1)
         begin
            if (c[7] ^ word[i])
               c = {c[6:0], 1'b0} ^ `GSC_CRC_POLY;
            else
               c = {c[6:0], 1'b0};
         end
         crc8 = c;
      end
   endfunction

   reg [1:0] scl_sync; // two-stage synchroniser for clock pin
   reg [1:0] sda_sync; // two-stage synchroniser for data pin
   reg scl_d; // previous synchronised clock
   reg sda_d; // previous synchronised data
   reg [2:0] state; // bit engine state
   reg [3:0] bit_cnt; // bits in the current byte
   reg [7:0] shreg; // received byte
   reg [7:0] tx; // byte being sent
   reg rw; // current transfer is a read
   reg host_ack; // host acknowledged last byte
   reg [2:0] byte_no; // bytes received after the address
   reg [15:0] cmd; // latched command code
   reg [15:0] arg; // latched argument
   reg temp_written; // host temperature in effect
   reg recal_pend; // recalibration waits for argument or stop
   reg [3:0] rd_idx; // readout byte index
   reg [15:0] w_conc; // captured concentration
   reg [15:0] w_temp; // captured temperature
   reg [15:0] w_res; // captured reserved word
   reg loading; // result bytes being written to memory
   reg [3:0] ld_idx; // byte being written
   reg [7:0] ld_byte; // byte for this load step
   wire [7:0] mem_rdata; // registered readout byte

   // edge and bus condition detection on synchronised pins
   wire scl_s = scl_sync[1];
   wire sda_s = sda_sync[1];
   wire scl_rise = scl_s & ~scl_d;
   wire scl_fall = ~scl_s & scl_d;
   wire bus_start = scl_s & scl_d & sda_d & ~sda_s;
   wire bus_stop = scl_s & scl_d & ~sda_d & sda_s;
   wire [15:0] rx_word = {arg[15:8], shreg};
   wire crc_ok = (shreg == crc8(arg));

   // next readout index; checksum bytes skipped when disabled
   wire [3:0] next_idx = (!crc_enabled && (rd_idx == 4'h1 || rd_idx == 4'h4 || rd_idx == 4'h7)) ?
      rd_idx + 4'h2 : rd_idx + 4'h1;

   // readout byte order: word msb, word lsb, checksum
   always @*
   begin
      case (ld_idx)
         4'h0: ld_byte = w_conc[15:8];
         4'h1: ld_byte = w_conc[7:0];
         4'h2: ld_byte = crc8(w_conc);
         4'h3: ld_byte = w_temp[15:8];
         4'h4: ld_byte = w_temp[7:0];
         4'h5: ld_byte = crc8(w_temp);
         4'h6: ld_byte = w_res[15:8];
         4'h7: ld_byte = w_res[7:0];
         4'h8: ld_byte = crc8(w_res);
         default: ld_byte = 8'h00;
      endcase
   end

   gsc_result_mem u_mem
   (
      .sys_clk(sys_clk),
      .wr_en(loading),
      .wr_addr(ld_idx),
      .wr_data(ld_byte),
      .rd_addr(rd_idx),
      .rd_data(mem_rdata)
   );

   // pin synchronisers
   always @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         scl_sync <= 2'b11;
         sda_sync <= 2'b11;
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end
      else
      begin
         scl_sync <= {scl_sync[0], scl_in};
         sda_sync <= {sda_sync[0], sda_in};
         scl_d <= scl_s;
         sda_d <= sda_s;
      end
   end

   // result capture and byte loader
   always @(posedge sys_clk)
   begin
      if (!rst_b || restore_defaults)
      begin
         meas_busy <= 1'b0;
         loading <= 1'b0;
         ld_idx <= 4'h0;
         w_conc <= 16'h0000;
         w_temp <= 16'h0000;
         w_res <= 16'h0000;
      end
      else
      begin
         if (meas_start)
         begin
            meas_busy <= 1'b1; // recalibration shares measurement time
         end
         else if (meas_done && meas_busy)
         begin
            meas_busy <= 1'b0;
            loading <= ~meas_recal;
            ld_idx <= 4'h0;
            w_conc <= meas_conc;
            w_temp <= temp_written ? comp_temp : internal_temp;
            w_res <= meas_reserved;
         end
         else if (loading)
         begin
            ld_idx <= ld_idx + 4'h1;
            if (ld_idx == `GSC_RD_LAST)
               loading <= 1'b0;
         end
      end
   end

   // i2c engine, command decode and stored compensation values
   always @(posedge sys_clk)
   begin
      if (!rst_b || restore_defaults)
      begin
         state <= ST_IDLE;
         bit_cnt <= 4'h0;
         shreg <= 8'h00;
         tx <= 8'h00;
         rw <= 1'b0;
         host_ack <= 1'b0;
         byte_no <= 3'd0;
         cmd <= 16'h0000;
         arg <= 16'h0000;
         sda_out <= 1'b0;
         sda_oe <= 1'b0;
         meas_start <= 1'b0;
         meas_recal <= 1'b0;
         recal_ref <= `GSC_REF_DEFAULT;
         recal_pend <= 1'b0;
         comp_rh <= `GSC_RH_DEFAULT;
         comp_temp <= `GSC_TEMP_DEFAULT;
         temp_written <= 1'b0;
         comp_press <= `GSC_PRESS_DEFAULT;
         crc_enabled <= 1'b1;
         data_ready <= 1'b0;
         rd_idx <= 4'h0;
      end
      else
      begin
         meas_start <= 1'b0;
         // result ready once all bytes sit in memory
         if (loading && ld_idx == `GSC_RD_LAST)
            data_ready <= 1'b1;
         if (bus_start)
         begin
            // start or repeated start: receive address
            state <= ST_ADDR;
            bit_cnt <= 4'h0;
            sda_oe <= 1'b0;
            byte_no <= 3'd0;
            recal_pend <= 1'b0;
         end
         else if (bus_stop)
         begin
            // stop: recalibration without argument uses zero
            if (recal_pend && !meas_busy)
            begin
               meas_start <= 1'b1;
               meas_recal <= 1'b1;
               recal_ref <= `GSC_REF_DEFAULT;
            end
            recal_pend <= 1'b0;
            state <= ST_IDLE;
            sda_oe <= 1'b0;
         end
         else
         begin
            case (state)
               ST_ADDR, ST_WR:
               begin
                  if (scl_rise)
                  begin
                     shreg <= {shreg[6:0], sda_s};
                     bit_cnt <= bit_cnt + 4'h1;
                  end
                  else if (scl_fall && bit_cnt == `GSC_BITS)
                  begin
                     bit_cnt <= 4'h0;
                     state <= ST_ACK;
                     sda_oe <= 1'b1;
                     if (state == ST_ADDR)
                     begin
                        rw <= shreg[0];
                        // read header nacked while no result is ready or no gas is selected
                        if (shreg[7:1] != dev_addr ||
                            (shreg[0] && !(data_ready && gas_selected)))
                        begin
                           state <= ST_IDLE;
                           sda_oe <= 1'b0;
                        end
                        else if (shreg[0])
                        begin
                           data_ready <= loading && (ld_idx == `GSC_RD_LAST); // a load wins
                           rd_idx <= 4'h0;
                        end
                     end
                     else
                     begin
                        byte_no <= (byte_no == 3'd5) ? byte_no : byte_no + 3'd1;
                        case (byte_no)
                           3'd0: cmd[15:8] <= shreg;
                           3'd1:
                           begin
                              cmd <= {cmd[15:8], shreg};
                              if ({cmd[15:8], shreg} == `GSC_CMD_CRC_OFF)
                                 crc_enabled <= 1'b0;
                              if ({cmd[15:8], shreg} == `GSC_CMD_MEASURE && !meas_busy)
                              begin
                                 meas_start <= 1'b1;
                                 meas_recal <= 1'b0;
                              end
                              if ({cmd[15:8], shreg} == `GSC_CMD_RECAL)
                                 recal_pend <= 1'b1;
                           end
                           3'd2: arg[15:8] <= shreg;
                           3'd3:
                           begin
                              arg <= rx_word;
                              if (!crc_enabled)
                              begin
                                 // unchecked argument applies at once
                                 recal_pend <= 1'b0;
                                 case (cmd)
                                    `GSC_CMD_SET_RH: comp_rh <= rx_word;
                                    `GSC_CMD_SET_TEMP:
                                    begin
                                       comp_temp <= rx_word;
                                       temp_written <= 1'b1;
                                    end
                                    `GSC_CMD_SET_PRESS: comp_press <= rx_word;
                                    `GSC_CMD_RECAL:
                                    begin
                                       meas_start <= ~meas_busy;
                                       meas_recal <= meas_recal | ~meas_busy;
                                       recal_ref <= meas_busy ? recal_ref : rx_word;
                                    end
                                    default: cmd <= cmd;
                                 endcase
                              end
                           end
                           3'd4:
                           begin
                              if (crc_enabled)
                              begin
                                 // checksum byte: apply or nack on this byte
                                 recal_pend <= 1'b0;
                                 if (!crc_ok)
                                 begin
                                    state <= ST_IDLE;
                                    sda_oe <= 1'b0;
                                 end
                                 case (cmd)
                                    `GSC_CMD_SET_RH:
                                       if (crc_ok)
                                          comp_rh <= arg;
                                    `GSC_CMD_SET_TEMP:
                                       if (crc_ok)
                                       begin
                                          comp_temp <= arg;
                                          temp_written <= 1'b1;
                                       end
                                    `GSC_CMD_SET_PRESS:
                                       if (crc_ok)
                                          comp_press <= arg;
                                    `GSC_CMD_RECAL:
                                    begin
                                       meas_start <= ~meas_busy;
                                       meas_recal <= meas_recal | ~meas_busy;
                                       if (!meas_busy)
                                          recal_ref <= crc_ok ? arg : `GSC_REF_DEFAULT;
                                    end
                                    default: cmd <= cmd;
                                 endcase
                              end
                           end
                           default: cmd <= cmd;
                        endcase
                     end
                  end
               end
               ST_ACK:
               begin
                  // hold acknowledge through the ninth clock
                  if (scl_rise)
                     bit_cnt <= 4'h1;
                  else if (scl_fall && bit_cnt == 4'h1)
                  begin
                     if (rw)
                     begin
                        state <= ST_RD;
                        tx <= mem_rdata;
                        sda_oe <= ~mem_rdata[7];
                        bit_cnt <= 4'h1;
                     end
                     else
                     begin
                        state <= ST_WR;
                        sda_oe <= 1'b0;
                        bit_cnt <= 4'h0;
                     end
                  end
               end
               ST_RD:
               begin
                  // shift out msb first on each falling clock
                  if (scl_fall)
                  begin
                     if (bit_cnt == `GSC_BITS)
                     begin
                        sda_oe <= 1'b0;
                        state <= ST_RACK;
                        bit_cnt <= 4'h0;
                        rd_idx <= next_idx;
                     end
                     else
                     begin
                        tx <= {tx[6:0], 1'b0};
                        sda_oe <= ~tx[6];
                        bit_cnt <= bit_cnt + 4'h1;
                     end
                  end
               end
               ST_RACK:
               begin
                  // host ack continues, nack ends the read
                  if (scl_rise)
                  begin
                     host_ack <= ~sda_s;
                     bit_cnt <= 4'h1;
                  end
                  else if (scl_fall && bit_cnt == 4'h1)
                  begin
                     if (host_ack && rd_idx < `GSC_RD_BYTES)
                     begin
                        state <= ST_RD;
                        tx <= mem_rdata;
                        sda_oe <= ~mem_rdata[7];
                     end
                     else
                     begin
                        state <= ST_IDLE;
                        sda_oe <= 1'b0;
                        bit_cnt <= 4'h0;
                     end
                  end
               end
               default:
               begin
                  state <= ST_IDLE;
                  sda_oe <= 1'b0;
               end
            endcase
         end
      end
   end
endmodule

// ---- hdl/gsc_result_mem.v ----
// readout byte memory with registered read data
`timescale 1ns/10ps
module gsc_result_mem
(
   // clock
   input wire sys_clk,
   // write port
   input wire wr_en,
   input wire [3:0] wr_addr,
   input wire [7:0] wr_data,
   // read port
   input wire [3:0] rd_addr,
   output reg [7:0] rd_data
);
   reg [7:0] mem [0:15]; // readout bytes

   // write and registered read
   always @(posedge sys_clk)
   begin
      if (wr_en)
      begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end
endmodule

// ---- include/gsc_regs.vh ----
// constants of the gas sensor compensation command handler
`ifndef GSC_REGS_VH
`define GSC_REGS_VH
// command codes
`define GSC_CMD_CRC_OFF 16'h3768
`define GSC_CMD_SET_RH 16'h3624
`define GSC_CMD_SET_TEMP 16'h361E
`define GSC_CMD_SET_PRESS 16'h362F
`define GSC_CMD_MEASURE 16'h3639
`define GSC_CMD_RECAL 16'h3661
// defaults after power-up, soft reset or wake-up
`define GSC_RH_DEFAULT 16'h0000
`define GSC_PRESS_DEFAULT 16'h03F5
`define GSC_TEMP_DEFAULT 16'h0000
`define GSC_REF_DEFAULT 16'h0000
// checksum: polynomial and start value
`define GSC_CRC_POLY 8'h31
`define GSC_CRC_INIT 8'hFF
// readout layout: three words, each with a checksum byte
`define GSC_RD_BYTES 4'h9
`define GSC_RD_LAST 4'h8
`define GSC_IDX_W 4
`define GSC_MEM_DEPTH 16
// bit engine
`define GSC_BITS 4'h8
`endif

// ---- verif/gsc_cmd_props.sv ----
// checker of the command handler port behaviour
`timescale 1ns/10ps
module gsc_cmd_props
(
   // clock and reset
   input wire sys_clk,
   input wire rst_b,
   // control and pin
   input wire restore_defaults,
   input wire sda_out,
   // measurement core side
   input wire meas_start,
   input wire meas_recal,
   input wire [15:0] recal_ref,
   input wire meas_done,
   input wire meas_busy,
   input wire data_ready,
   // settings in effect
   input wire [15:0] comp_rh,
   input wire [15:0] comp_press,
   input wire crc_enabled
);
   // one domain: every check on the system clock, off in reset
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   // soft reset or wake-up brings the defaults back
   defaults_back_a: assert property (restore_defaults |=>
      comp_rh == 16'h0000 && comp_press == 16'h03F5 && crc_enabled && !data_ready)
      else $error("defaults not restored");
   // open drain: the pin value is only ever low
   drive_low_a: assert property (sda_out == 1'b0)
      else $error("sda value not low");
   // a start is one cycle long and opens a busy job
   start_busy_a: assert property (meas_start |=> meas_busy && !meas_start)
      else $error("start not followed by busy");
   // a job lasts until the core reports it done
   busy_hold_a: assert property (
      meas_busy && !meas_done && !restore_defaults |=> meas_busy)
      else $error("busy dropped early");
   // job settings hold still while it runs
   ref_hold_a: assert property (
      meas_busy |-> $stable(recal_ref) && $stable(meas_recal))
      else $error("recal settings moved in a job");
   // a finished measurement lands in the readout soon after
   result_load_a: assert property (
      meas_done && meas_busy && !meas_recal |-> ##[1:15] data_ready)
      else $error("result not loaded");
   // a recalibration leaves no new readout behind
   recal_quiet_a: assert property (
      meas_done && meas_busy && meas_recal && !data_ready |=> !data_ready [*8])
      else $error("recal produced readout");
   // checksum handling comes back only through the defaults
   crc_back_a: assert property ($rose(crc_enabled) |-> $past(restore_defaults))
      else $error("checksum enabled without restore");
   // main scenarios reached
   cover property (meas_start && meas_recal);
   cover property ($rose(data_ready));
   cover property ($fell(crc_enabled));
endmodule
bind gsc_cmd gsc_cmd_props u_props (.sys_clk(sys_clk), .rst_b(rst_b),
   .restore_defaults(restore_defaults), .sda_out(sda_out), .meas_start(meas_start),
   .meas_recal(meas_recal), .recal_ref(recal_ref), .meas_done(meas_done),
   .meas_busy(meas_busy), .data_ready(data_ready), .comp_rh(comp_rh),
   .comp_press(comp_press), .crc_enabled(crc_enabled));

// ---- verif/gsc_cmd_tb.sv ----
// self-checking bench of the command handler
`timescale 1ns/10ps
`include "gsc_regs.vh"
`define CHK(nm, ex, gt) begin checks = checks + 1; if ((gt) !== (ex)) begin \
   num_errors = num_errors + 1; \
   $display("FAIL %s expected %h seen %h", nm, ex, gt); end end
module gsc_cmd_tb;
   // clock, reset and control
   reg sys_clk, rst_b, restore_defaults, gas_selected;
   reg [6:0] dev_addr;
   // measurement core stand-in
   reg meas_done = 1'b0;
   reg [15:0] meas_conc, internal_temp, meas_reserved;
   integer busy_cnt = 0;
   // design outputs and pins
   wire scl, host_pull, sda_out, sda_oe, meas_start, meas_recal, meas_busy;
   wire crc_enabled, data_ready;
   wire [15:0] recal_ref, comp_rh, comp_temp, comp_press;
   wire sda = !(sda_oe | host_pull);
   // bench bookkeeping
   integer num_errors = 0, checks = 0, cyc = 0, starts = 0;
   reg [7:0] rx [0:8];
   reg last_nack, got_recal;
   reg [15:0] got_ref;
   gsc_cmd uut (.sys_clk(sys_clk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe(sda_oe), .dev_addr(dev_addr),
      .restore_defaults(restore_defaults), .gas_selected(gas_selected),
      .meas_start(meas_start), .meas_recal(meas_recal), .recal_ref(recal_ref),
      .meas_done(meas_done), .meas_conc(meas_conc), .internal_temp(internal_temp),
      .meas_reserved(meas_reserved), .comp_rh(comp_rh), .comp_temp(comp_temp),
      .comp_press(comp_press), .crc_enabled(crc_enabled), .meas_busy(meas_busy),
      .data_ready(data_ready));
   gsc_host_model host (.sys_clk(sys_clk), .sda(sda), .scl(scl), .host_pull(host_pull));
   // 100 mhz clock
   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // core stand-in: each job ends 200 cycles after its start
   always @(negedge sys_clk)
   begin
      meas_done <= 1'b0;
      if (meas_start === 1'b1)
         busy_cnt <= 200;
      else if (busy_cnt > 0)
      begin
         busy_cnt <= busy_cnt - 1;
         meas_done <= (busy_cnt == 1);
      end
   end
   // capture job settings at each start; hang guard
   always @(posedge sys_clk)
   begin
      cyc = cyc + 1;
      if (meas_start === 1'b1)
      begin
         starts = starts + 1;
         got_ref = recal_ref;
         got_recal = meas_recal;
      end
      if (cyc == 40000)
      begin
         num_errors = num_errors + 1;
         wrap_up;
      end
   end
   // checksum of a word, msb first
   function automatic [7:0] crc_of(input [15:0] w);
      integer i;
      reg [7:0] c;
      begin
         c = 8'hFF;
         for (i = 15; i >= 0; i = i - 1)
            c = (c[7] ^ w[i]) ? ({c[6:0], 1'b0} ^ 8'h31) : {c[6:0], 1'b0};
         crc_of = c;
      end
   endfunction
   // write transfer; last_nack holds the ninth bit of the final byte
   task wr_cmd(input [15:0] cmd, input has_arg, input [15:0] arg, input [7:0] flip,
               input send_crc);
      logic [7:0] r;
      logic s;
      host.start;
      host.byte_io({dev_addr, 1'b0}, 1'b1, r, s);
      host.byte_io(cmd[15:8], 1'b1, r, s);
      host.byte_io(cmd[7:0], 1'b1, r, last_nack);
      if (has_arg)
      begin
         host.byte_io(arg[15:8], 1'b1, r, s);
         host.byte_io(arg[7:0], 1'b1, r, last_nack);
         if (send_crc)
            host.byte_io(crc_of(arg) ^ flip, 1'b1, r, last_nack);
      end
      host.stop;
      host.tick(4);
   endtask
   // read header then n bytes, nack on the last, then stop
   task rd_result(input integer n);
      logic [7:0] r;
      integer i;
      host.start;
      host.byte_io({dev_addr, 1'b1}, 1'b1, r, last_nack);
      for (i = 0; i < n && last_nack === 1'b0; i = i + 1)
         host.byte_io(8'hFF, i == n - 1, rx[i], r[0]);
      host.stop;
   endtask
   // wait for the running job to end, then for the loader
   task settle;
      integer k;
      for (k = 0; k < 400 && (meas_busy !== 1'b0 || busy_cnt > 0); k = k + 1)
         @(negedge sys_clk);
      `CHK("job ended", 1'b0, meas_busy)
      host.tick(20);
   endtask
   // soft reset / wake-up pulse
   task do_restore;
      restore_defaults = 1'b1;
      host.tick(2);
      restore_defaults = 1'b0;
      host.tick(4);
   endtask
   // measure, check early nack, read n bytes against the expected frame
   task measure(input integer n, input [15:0] t);
      logic [71:0] e;
      integer i;
      e = {meas_conc, crc_of(meas_conc), t, crc_of(t), meas_reserved, crc_of(meas_reserved)};
      wr_cmd(`GSC_CMD_SET_PRESS, 1'b1, 16'h03E8, 8'h00, 1'b1);
      wr_cmd(`GSC_CMD_MEASURE, 1'b0, 16'h0000, 8'h00, 1'b0);
      rd_result(0);
      `CHK("early header", 1'b1, last_nack)
      settle;
      rd_result(n);
      `CHK("ready header", 1'b0, last_nack)
      for (i = 0; i < n; i = i + 1)
         `CHK("readout byte", e[71 - 8 * i -: 8], rx[i])
      `CHK("bus released", 1'b0, sda_oe)
   endtask
   task t_defaults;
      `CHK("rh default", 16'h0000, comp_rh)
      `CHK("press default", 16'h03F5, comp_press)
      `CHK("crc default", 1'b1, crc_enabled)
   endtask
   task t_compensation;
      wr_cmd(`GSC_CMD_SET_RH, 1'b1, 16'h8000, 8'h01, 1'b1);
      `CHK("rh bad nack", 1'b1, last_nack)
      `CHK("rh zero kept", 16'h0000, comp_rh)
      wr_cmd(`GSC_CMD_SET_RH, 1'b1, 16'h8000, 8'h00, 1'b1);
      `CHK("rh ack", 1'b0, last_nack)
      wr_cmd(`GSC_CMD_SET_PRESS, 1'b1, 16'h05DC, 8'h80, 1'b1);
      `CHK("press default kept", 16'h03F5, comp_press)
      wr_cmd(`GSC_CMD_SET_PRESS, 1'b1, 16'h02EE, 8'h00, 1'b1);
      wr_cmd(`GSC_CMD_SET_PRESS, 1'b1, 16'h05DC, 8'h80, 1'b1);
      `CHK("press bad nack", 1'b1, last_nack)
      `CHK("press kept", 16'h02EE, comp_press)
      `CHK("rh kept", 16'h8000, comp_rh)
      wr_cmd(`GSC_CMD_SET_TEMP, 1'b1, 16'hFF38, 8'h00, 1'b1);
      wr_cmd(`GSC_CMD_SET_TEMP, 1'b1, 16'h0100, 8'h01, 1'b1);
      `CHK("temp bad nack", 1'b1, last_nack)
      `CHK("temp kept", 16'hFF38, comp_temp)
   endtask
   task t_readout;
      do_restore;
      gas_selected = 1'b0;
      wr_cmd(`GSC_CMD_MEASURE, 1'b0, 16'h0000, 8'h00, 1'b0);
      settle;
      rd_result(0);
      `CHK("no gas header", 1'b1, last_nack)
      gas_selected = 1'b1;
      rd_result(3);
      `CHK("short read", {meas_conc, crc_of(meas_conc)}, {rx[0], rx[1], rx[2]})
      measure(9, internal_temp);
      wr_cmd(`GSC_CMD_SET_TEMP, 1'b1, 16'hFF38, 8'h00, 1'b1);
      measure(5, 16'hFF38);
   endtask
   task t_recal;
      wr_cmd(`GSC_CMD_RECAL, 1'b1, 16'h0190, 8'h00, 1'b1);
      `CHK("recal ref", 16'h0190, got_ref)
      `CHK("recal kind", 1'b1, got_recal)
      settle;
      `CHK("recal no data", 1'b0, data_ready)
      got_ref = 16'hAAAA;
      wr_cmd(`GSC_CMD_RECAL, 1'b0, 16'h0000, 8'h00, 1'b0);
      `CHK("recal no arg", 16'h0000, got_ref)
      settle;
      got_ref = 16'hAAAA;
      wr_cmd(`GSC_CMD_RECAL, 1'b1, 16'h0190, 8'h04, 1'b1);
      `CHK("recal bad nack", 1'b1, last_nack)
      `CHK("recal bad ref", 16'h0000, got_ref)
      settle;
   endtask
   task t_crc_off;
      wr_cmd(`GSC_CMD_CRC_OFF, 1'b0, 16'h0000, 8'h00, 1'b0);
      `CHK("crc off", 1'b0, crc_enabled)
      wr_cmd(`GSC_CMD_SET_RH, 1'b1, 16'h1234, 8'h00, 1'b0);
      `CHK("rh no crc", 16'h1234, comp_rh)
      wr_cmd(`GSC_CMD_MEASURE, 1'b0, 16'h0000, 8'h00, 1'b0);
      settle;
      rd_result(4);
      `CHK("no crc read", {meas_conc, 16'hFF38}, {rx[0], rx[1], rx[2], rx[3]})
      do_restore;
      t_defaults;
      wr_cmd(`GSC_CMD_RECAL, 1'b1, 16'h0190, 8'h00, 1'b1);
      `CHK("ref restored", 16'h0190, got_ref)
      settle;
   endtask
   // closing report
   task wrap_up;
      $display("checks %0d num_errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // main sequence
   initial
   begin
      rst_b = 1'b0;
      restore_defaults = 1'b0;
      gas_selected = 1'b1;
      dev_addr = 7'h29;
      meas_conc = 16'h1A2B;
      internal_temp = 16'h0C80;
      meas_reserved = 16'h5A5A;
      repeat (6) @(negedge sys_clk);
      rst_b = 1'b1;
      host.tick(4);
      t_defaults;
      t_compensation;
      t_readout;
      t_recal;
      t_crc_off;
      wrap_up;
   end
endmodule

// ---- verif/gsc_host_model.sv ----
// i2c host controller model driving the sensor pins
`timescale 1ns/10ps
module gsc_host_model
(
   // bench clock
   input wire sys_clk,
   // resolved sda level
   input wire sda,
   // host pins: scl and sda pull-down
   output reg scl,
   output reg host_pull
);
   // bus idle: both lines released high
   initial
   begin
      scl = 1'b1;
      host_pull = 1'b0;
   end
   // wait bench cycles; changes land after a falling edge
   task tick(input integer n);
      repeat (n) @(negedge sys_clk);
   endtask
   // one scl period of 80 ns: put b on the wire, sample at end of high
   task clk_bit(input logic b, output logic s);
      tick(1);
      host_pull = !b;
      tick(3);
      scl = 1'b1;
      tick(4);
      s = sda;
      scl = 1'b0;
   endtask
   // start: sda falls while scl high, after the device let go of sda
   task start;
      tick(1);
      host_pull = 1'b0;
      tick(7);
      scl = 1'b1;
      tick(4);
      host_pull = 1'b1;
      tick(4);
      scl = 1'b0;
   endtask
   // stop: sda rises while scl high; scl then stands still high
   task stop;
      tick(1);
      host_pull = 1'b1;
      tick(3);
      scl = 1'b1;
      tick(4);
      host_pull = 1'b0;
      tick(4);
   endtask
   // eight bits msb first, then the ninth bit; nine high releases sda
   task byte_io(input logic [7:0] tx, input logic nine, output logic [7:0] rx,
                output logic s9);
      integer i;
      logic s;
      for (i = 7; i >= 0; i = i - 1)
      begin
         clk_bit(tx[i], s);
         rx[i] = s;
      end
      clk_bit(nine, s9);
   endtask
endmodule
